// [verilog/smsc_pkg.sv]
package smsc_pkg;

  // ****************************************************************
  // frame characters
  // ****************************************************************
  localparam logic [7:0] ENQ_C      = 8'h05;
  localparam logic [7:0] EOT_C      = 8'h04;
  localparam logic [7:0] ACK_C      = 8'h06;
  localparam logic [7:0] NAK_C      = 8'h15;
  localparam logic [7:0] ETX_C      = 8'h03;
  localparam logic [7:0] CMD_MON    = 8'h59;
  localparam logic [7:0] CMD_RD     = 8'h52;
  localparam logic [7:0] CASE_MASK  = 8'h20;
  localparam logic [7:0] TYPE_HI    = 8'h53;
  localparam logic [7:0] TYPE_LO    = 8'h54;
  localparam logic [7:0] ASC_ZERO   = 8'h30;
  localparam logic [7:0] ASC_NINE   = 8'h39;
  localparam logic [7:0] ASC_A      = 8'h41;
  localparam logic [7:0] ASC_F      = 8'h46;
  localparam logic [7:0] ASC_LETTER = 8'h37;
  localparam logic [3:0] NIB_TEN    = 4'hA;
  localparam logic [3:0] NIB_NINE   = 4'h9;

  // ****************************************************************
  // limits, counts and error codes
  // ****************************************************************
  localparam logic [7:0]  REG_SLOTS  = 8'h0A;
  localparam logic [5:0]  BLK_MAX    = 6'h10;
  localparam logic [5:0]  DATA_MAX   = 6'h3C;
  localparam logic [5:0]  WORD_LEN   = 6'h02;
  localparam int unsigned STAT_BITS  = 160;
  localparam logic [5:0]  STAT_LAST  = 6'h27;
  localparam logic [5:0]  ECHO_LAST  = 6'h04;
  localparam logic [5:0]  ERR_LAST   = 6'h03;
  localparam logic [5:0]  PAIR_LAST  = 6'h01;
  localparam logic [15:0] ERR_DATA   = 16'h0011;
  localparam logic [15:0] ERR_CMD    = 16'h0021;
  localparam logic [15:0] ERR_TYPE   = 16'h0031;
  localparam logic [15:0] ERR_DEVICE = 16'h1132;

  // ****************************************************************
  // monitor table entry: kind, count, base address
  // ****************************************************************
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned CNT_W    = 6;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned ENTRY_W  = 1 + CNT_W + ADDR_W;
  localparam int unsigned KIND_BIT = ENTRY_W - 1;

  typedef enum logic [17:0] {
    S_IDLE  = 18'h0_0001,
    S_RSTA  = 18'h0_0002,
    S_RCMD  = 18'h0_0004,
    S_RARG  = 18'h0_0008,
    S_REOT  = 18'h0_0010,
    S_RBCC  = 18'h0_0020,
    S_LOOK  = 18'h0_0040,
    S_THDR  = 18'h0_0080,
    S_TECHO = 18'h0_0100,
    S_TCNT  = 18'h0_0200,
    S_TLEN  = 18'h0_0400,
    S_FETCH = 18'h0_0800,
    S_WAIT  = 18'h0_1000,
    S_TDATA = 18'h0_2000,
    S_TSTAT = 18'h0_4000,
    S_TERR  = 18'h0_8000,
    S_TETX  = 18'h1_0000,
    S_TBCC  = 18'h2_0000
  } smsc_state_t;

  // ****************************************************************
  // hex helpers
  // ****************************************************************
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < NIB_TEN) ? ASC_ZERO + {4'h0, n}
                             : ASC_LETTER + {4'h0, n};
  endfunction : hex_char

  // bit 4 flags a legal uppercase hex digit
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= ASC_ZERO && c <= ASC_NINE)
      hex_val = {1'b1, c[3:0]};
    else if (c >= ASC_A && c <= ASC_F)
      hex_val = {1'b1, c[3:0] + NIB_NINE};
    else
      hex_val = 5'h00;
  endfunction : hex_val

  function automatic logic [3:0] pick_nib(input logic [7:0] b,
                                          input logic       lo);
    pick_nib = lo ? b[3:0] : b[7:4];
  endfunction : pick_nib

endpackage : smsc_pkg

// [verilog/smsc_table.sv]
`timescale 1ns/100ps
// ****************************************************************
// monitor registration table, registered read
// ****************************************************************
module smsc_table #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4,
  parameter int unsigned W     = 23
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_nrst,
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata,
  output logic               o_rvalid
);

  logic [W-1:0]     mem [DEPTH];
  logic [DEPTH-1:0] used_q;

  // storage; a write to a used slot simply replaces it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_wr)
      mem[i_waddr] <= i_wdata;
  end

  // occupancy must be known after reset, the words need not
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      used_q <= '0;
    else if (i_wr)
      used_q[i_waddr] <= 1'b1;
  end

  // read port, one cycle latency
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_rdata  <= '0;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rdata  <= mem[i_raddr];
      o_rvalid <= used_q[i_raddr];
    end
  end

endmodule : smsc_table

// [verilog/smsc_responder.sv]
`timescale 1ns/100ps
// What this block does
// - answer with current data of stored devices
// - lowercase request carries ENQ-to-EOT sum check
// - acknowledge layout follows stored entry kind
// - single: count, per block length+data, max 16
// - continuous: one length, data, ETX, check
// - replies echo station, letter, index verbatim
// - errors send NAK..ETX plus lowercase sum check
// - NAK carries four-character hex error code
// - lowercase status query carries sum check
// - status ACK echoes fields, record, ETX, check
// - status record is 20 bytes, 40 characters
// - ten slots, re-registering overwrites the slot
// - stored entry mirrors a read command body
module smsc_responder #(
  parameter int unsigned CNT_W  = 6,
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_nrst,
  input  wire logic [7:0]                 i_station,
  input  wire logic                       i_rx_valid,
  input  wire logic [7:0]                 i_rx_byte,
  output logic                            o_tx_valid,
  output logic      [7:0]                 o_tx_byte,
  input  wire logic                       i_tx_ready,
  input  wire logic                       i_reg_wr,
  input  wire logic [smsc_pkg::IDX_W-1:0] i_reg_idx,
  input  wire logic                       i_reg_single,
  input  wire logic [CNT_W-1:0]           i_reg_count,
  input  wire logic [ADDR_W-1:0]          i_reg_base,
  output logic                            o_dev_rd,
  output logic      [ADDR_W-1:0]          o_dev_addr,
  input  wire logic [7:0]                 i_dev_data,
  input  wire logic [smsc_pkg::STAT_BITS-1:0] i_status
);

  smsc_pkg::smsc_state_t state_q;
  logic [5:0]  pos_q;
  logic [7:0]  sta0_q, sta1_q, cmd_q, arg0_q, arg1_q, bcc0_q;
  logic [7:0]  rsum_q, tsum_q, data_q;
  logic        nak_q, stat_q, single_q;
  logic [15:0] err_q;
  logic [5:0]  cnt_q, rem_q, blk_q;
  logic [smsc_pkg::ENTRY_W-1:0] ent;
  logic        ent_ok, lower, rx_start, fire, emit, reg_ok;
  logic [4:0]  hx, sh0, sh1, ah0, ah1, bh0;
  logic [7:0]  upper, idx, stat_byte, char_d;
  logic        sta_match, bcc_good, dec_nak;
  logic [15:0] dec_err;
  smsc_pkg::smsc_state_t dec_state;

  // ****************************************************************
  // registration table
  // ****************************************************************
  assign reg_ok = {4'h0, i_reg_idx} < smsc_pkg::REG_SLOTS;

  // slots above the limit are never written, so never valid
  smsc_table #(
    .DEPTH (16),
    .AW    (smsc_pkg::IDX_W),
    .W     (smsc_pkg::ENTRY_W)
  ) u_table (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_wr      (i_reg_wr && reg_ok),
    .i_waddr   (i_reg_idx),
    .i_wdata   ({i_reg_single, i_reg_count, i_reg_base}),
    .i_raddr   (idx[smsc_pkg::IDX_W-1:0]),
    .o_rdata   (ent),
    .o_rvalid  (ent_ok)
  );

  // ****************************************************************
  // request decode
  // ****************************************************************
  // frame verdict, evaluated in the cycle of the last request byte
  always_comb
  begin
    hx        = smsc_pkg::hex_val(i_rx_byte);
    sh0       = smsc_pkg::hex_val(sta0_q);
    sh1       = smsc_pkg::hex_val(sta1_q);
    ah0       = smsc_pkg::hex_val(arg0_q);
    ah1       = smsc_pkg::hex_val(arg1_q);
    bh0       = smsc_pkg::hex_val(bcc0_q);
    idx       = {ah0[3:0], ah1[3:0]};
    lower     = (cmd_q & smsc_pkg::CASE_MASK) != 8'h00;
    upper     = cmd_q & ~smsc_pkg::CASE_MASK;
    rx_start  = i_rx_valid && i_rx_byte == smsc_pkg::ENQ_C;
    sta_match = sh0[4] && sh1[4] && {sh0[3:0], sh1[3:0]} == i_station;
    bcc_good  = !lower || (bh0[4] && hx[4] &&
                {bh0[3:0], hx[3:0]} == rsum_q);
    dec_state = smsc_pkg::S_THDR;
    dec_nak   = 1'b1;
    dec_err   = smsc_pkg::ERR_CMD;
    if (!sta_match)
      dec_state = smsc_pkg::S_IDLE;
    else if (!bcc_good)
      dec_err = smsc_pkg::ERR_DATA;
    else if (upper == smsc_pkg::CMD_MON)
    begin
      if (!(ah0[4] && ah1[4]))
        dec_err = smsc_pkg::ERR_DATA;
      else if (idx >= smsc_pkg::REG_SLOTS)
        dec_err = smsc_pkg::ERR_DEVICE;
      else
      begin
        dec_state = smsc_pkg::S_LOOK;
        dec_nak   = 1'b0;
      end
    end
    else if (upper == smsc_pkg::CMD_RD)
    begin
      if (arg0_q == smsc_pkg::TYPE_HI && arg1_q == smsc_pkg::TYPE_LO)
        dec_nak = 1'b0;
      else
        dec_err = smsc_pkg::ERR_TYPE;
    end
  end

  // raw request fields, kept for the verbatim echo
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sta0_q <= 8'h00;
      sta1_q <= 8'h00;
      cmd_q  <= 8'h00;
      arg0_q <= 8'h00;
      arg1_q <= 8'h00;
      bcc0_q <= 8'h00;
      rsum_q <= 8'h00;
    end
    else if (rx_start && state_q inside {smsc_pkg::S_IDLE,
             smsc_pkg::S_RSTA, smsc_pkg::S_RCMD, smsc_pkg::S_RARG,
             smsc_pkg::S_REOT, smsc_pkg::S_RBCC})
      rsum_q <= smsc_pkg::ENQ_C;
    else if (i_rx_valid)
    begin
      case (state_q)
        smsc_pkg::S_RSTA:
        begin
          if (pos_q == 6'h00) sta0_q <= i_rx_byte;
          else sta1_q <= i_rx_byte;
          rsum_q <= rsum_q + i_rx_byte;
        end
        smsc_pkg::S_RCMD:
        begin
          cmd_q  <= i_rx_byte;
          rsum_q <= rsum_q + i_rx_byte;
        end
        smsc_pkg::S_RARG:
        begin
          if (pos_q == 6'h00) arg0_q <= i_rx_byte;
          else arg1_q <= i_rx_byte;
          rsum_q <= rsum_q + i_rx_byte;
        end
        smsc_pkg::S_REOT: rsum_q <= rsum_q + i_rx_byte;
        smsc_pkg::S_RBCC: if (pos_q == 6'h00) bcc0_q <= i_rx_byte;
        default: rsum_q <= rsum_q;
      endcase
    end
  end

  // ****************************************************************
  // reply character selection
  // ****************************************************************
  assign stat_byte = 8'(i_status >> {pos_q[5:1], 3'b000});
  assign emit = state_q inside {smsc_pkg::S_THDR, smsc_pkg::S_TECHO,
                smsc_pkg::S_TCNT, smsc_pkg::S_TLEN, smsc_pkg::S_TDATA,
                smsc_pkg::S_TSTAT, smsc_pkg::S_TERR, smsc_pkg::S_TETX,
                smsc_pkg::S_TBCC};
  assign fire = emit && (!o_tx_valid || i_tx_ready);

  // each field goes out high nibble first
  always_comb
  begin
    case (state_q)
      smsc_pkg::S_THDR:
        char_d = nak_q ? smsc_pkg::NAK_C : smsc_pkg::ACK_C;
      smsc_pkg::S_TECHO:
        case (pos_q[2:0])
          3'h0:    char_d = sta0_q;
          3'h1:    char_d = sta1_q;
          3'h2:    char_d = cmd_q;
          3'h3:    char_d = arg0_q;
          default: char_d = arg1_q;
        endcase
      smsc_pkg::S_TCNT:
        char_d = smsc_pkg::hex_char(smsc_pkg::pick_nib({2'b00, cnt_q},
                 pos_q[0]));
      smsc_pkg::S_TLEN:
        char_d = smsc_pkg::hex_char(smsc_pkg::pick_nib({2'b00,
                 single_q ? smsc_pkg::WORD_LEN : cnt_q}, pos_q[0]));
      smsc_pkg::S_TDATA:
        char_d = smsc_pkg::hex_char(smsc_pkg::pick_nib(data_q,
                 pos_q[0]));
      smsc_pkg::S_TSTAT:
        char_d = smsc_pkg::hex_char(smsc_pkg::pick_nib(stat_byte,
                 pos_q[0]));
      smsc_pkg::S_TERR:
        char_d = smsc_pkg::hex_char(smsc_pkg::pick_nib(pos_q[1] ?
                 err_q[7:0] : err_q[15:8], pos_q[0]));
      smsc_pkg::S_TETX: char_d = smsc_pkg::ETX_C;
      smsc_pkg::S_TBCC:
        char_d = smsc_pkg::hex_char(smsc_pkg::pick_nib(tsum_q,
                 pos_q[0]));
      default: char_d = 8'h00;
    endcase
  end

  // output holding register; a stalled character stays put
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_tx_valid <= 1'b0;
      o_tx_byte  <= 8'h00;
      tsum_q     <= 8'h00;
    end
    else if (fire)
    begin
      o_tx_valid <= 1'b1;
      o_tx_byte  <= char_d;
      if (state_q == smsc_pkg::S_THDR)
        tsum_q <= char_d;
      else if (state_q != smsc_pkg::S_TBCC)
        tsum_q <= tsum_q + char_d;
    end
    else if (i_tx_ready)
      o_tx_valid <= 1'b0;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // requests arriving while a reply is under way are dropped
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q  <= smsc_pkg::S_IDLE;
      pos_q    <= 6'h00;
      nak_q    <= 1'b0;
      stat_q   <= 1'b0;
      err_q    <= 16'h0000;
      single_q <= 1'b0;
      cnt_q    <= 6'h00;
      rem_q    <= 6'h00;
      blk_q    <= 6'h00;
      o_dev_rd   <= 1'b0;
      o_dev_addr <= '0;
      data_q   <= 8'h00;
    end
    else
    begin
      o_dev_rd <= state_q == smsc_pkg::S_FETCH;
      case (state_q)
        smsc_pkg::S_IDLE, smsc_pkg::S_RSTA, smsc_pkg::S_RCMD,
        smsc_pkg::S_RARG, smsc_pkg::S_REOT, smsc_pkg::S_RBCC:
          if (rx_start)
          begin
            state_q <= smsc_pkg::S_RSTA;
            pos_q   <= 6'h00;
          end
          else if (i_rx_valid)
          begin
            pos_q <= pos_q + 6'h01;
            case (state_q)
              smsc_pkg::S_RSTA:
                if (pos_q == smsc_pkg::PAIR_LAST)
                  state_q <= smsc_pkg::S_RCMD;
              smsc_pkg::S_RCMD:
              begin
                state_q <= smsc_pkg::S_RARG;
                pos_q   <= 6'h00;
              end
              smsc_pkg::S_RARG:
                if (pos_q == smsc_pkg::PAIR_LAST)
                  state_q <= smsc_pkg::S_REOT;
              smsc_pkg::S_REOT:
              begin
                pos_q <= 6'h00;
                if (i_rx_byte != smsc_pkg::EOT_C)
                  state_q <= smsc_pkg::S_IDLE;
                else if (lower)
                  state_q <= smsc_pkg::S_RBCC;
                else
                begin
                  state_q <= dec_state;
                  nak_q   <= dec_nak;
                  err_q   <= dec_err;
                  stat_q  <= upper == smsc_pkg::CMD_RD;
                end
              end
              smsc_pkg::S_RBCC:
                if (pos_q == smsc_pkg::PAIR_LAST)
                begin
                  pos_q   <= 6'h00;
                  state_q <= dec_state;
                  nak_q   <= dec_nak;
                  err_q   <= dec_err;
                  stat_q  <= upper == smsc_pkg::CMD_RD;
                end
              default: pos_q <= 6'h00;
            endcase
          end
        smsc_pkg::S_LOOK:
        begin
          single_q   <= ent[smsc_pkg::KIND_BIT];
          cnt_q      <= ent[smsc_pkg::KIND_BIT-1 -: CNT_W];
          blk_q      <= ent[smsc_pkg::KIND_BIT-1 -: CNT_W];
          o_dev_addr <= ent[ADDR_W-1:0];
          state_q    <= smsc_pkg::S_THDR;
          if (!ent_ok || ent[smsc_pkg::KIND_BIT-1 -: CNT_W] == 6'h00 ||
              ent[smsc_pkg::KIND_BIT-1 -: CNT_W] >
              (ent[smsc_pkg::KIND_BIT] ? smsc_pkg::BLK_MAX
                                       : smsc_pkg::DATA_MAX))
          begin
            nak_q <= 1'b1;
            err_q <= smsc_pkg::ERR_DEVICE;
          end
        end
        smsc_pkg::S_FETCH:
        begin
          state_q <= smsc_pkg::S_WAIT;
          pos_q   <= 6'h00;
        end
        smsc_pkg::S_WAIT:
          // one idle cycle lets the device answer the read pulse
          if (pos_q == smsc_pkg::PAIR_LAST)
          begin
            data_q     <= i_dev_data;
            o_dev_addr <= o_dev_addr + ADDR_W'(1);
            state_q    <= smsc_pkg::S_TDATA;
            pos_q      <= 6'h00;
          end
          else
            pos_q <= pos_q + 6'h01;
        default:
          if (fire)
          begin
            pos_q <= pos_q + 6'h01;
            case (state_q)
              smsc_pkg::S_THDR:
              begin
                state_q <= smsc_pkg::S_TECHO;
                pos_q   <= 6'h00;
              end
              smsc_pkg::S_TECHO:
                if (pos_q == smsc_pkg::ECHO_LAST)
                begin
                  pos_q   <= 6'h00;
                  state_q <= nak_q ? smsc_pkg::S_TERR :
                             stat_q ? smsc_pkg::S_TSTAT :
                             single_q ? smsc_pkg::S_TCNT :
                             smsc_pkg::S_TLEN;
                end
              smsc_pkg::S_TCNT, smsc_pkg::S_TLEN:
                if (pos_q == smsc_pkg::PAIR_LAST)
                begin
                  pos_q   <= 6'h00;
                  state_q <= (state_q == smsc_pkg::S_TCNT) ?
                             smsc_pkg::S_TLEN : smsc_pkg::S_FETCH;
                  rem_q   <= single_q ? smsc_pkg::WORD_LEN : cnt_q;
                end
              smsc_pkg::S_TDATA:
                if (pos_q == smsc_pkg::PAIR_LAST)
                begin
                  pos_q <= 6'h00;
                  rem_q <= rem_q - 6'h01;
                  if (rem_q > 6'h01)
                    state_q <= smsc_pkg::S_FETCH;
                  else if (single_q && blk_q > 6'h01)
                  begin
                    blk_q   <= blk_q - 6'h01;
                    state_q <= smsc_pkg::S_TLEN;
                  end
                  else
                    state_q <= smsc_pkg::S_TETX;
                end
              smsc_pkg::S_TSTAT:
                if (pos_q == smsc_pkg::STAT_LAST)
                  state_q <= smsc_pkg::S_TETX;
              smsc_pkg::S_TERR:
                if (pos_q == smsc_pkg::ERR_LAST)
                  state_q <= smsc_pkg::S_TETX;
              smsc_pkg::S_TETX:
              begin
                pos_q   <= 6'h00;
                state_q <= lower ? smsc_pkg::S_TBCC
                                 : smsc_pkg::S_IDLE;
              end
              smsc_pkg::S_TBCC:
                if (pos_q == smsc_pkg::PAIR_LAST)
                  state_q <= smsc_pkg::S_IDLE;
              default: state_q <= smsc_pkg::S_IDLE;
            endcase
          end
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence s_fetch;
    o_dev_rd ##1 (!o_dev_rd && state_q == smsc_pkg::S_WAIT)
    ##1 (state_q == smsc_pkg::S_TDATA && data_q == $past(i_dev_data));
  endsequence

  sequence s_tail_check;
    (state_q == smsc_pkg::S_TBCC) ##0 (pos_q == 6'h00);
  endsequence

  dev_fetch_a: assert property (
    state_q == smsc_pkg::S_FETCH |=> s_fetch)
    else $error("device data not captured two cycles after read");

  station_gate_a: assert property (
    state_q == smsc_pkg::S_THDR && !$past(state_q == smsc_pkg::S_THDR)
    |-> {sh0[3:0], sh1[3:0]} == i_station)
    else $error("reply started for a foreign station");

  lower_bcc_a: assert property (
    state_q == smsc_pkg::S_TETX && fire && lower |=> s_tail_check)
    else $error("lowercase reply lacks check field");

  upper_end_a: assert property (
    state_q == smsc_pkg::S_TETX && fire && !lower
    |=> state_q == smsc_pkg::S_IDLE)
    else $error("uppercase reply did not end at ETX");

  stat_len_a: assert property (
    state_q == smsc_pkg::S_TSTAT && fire && pos_q == smsc_pkg::STAT_LAST
    |=> state_q == smsc_pkg::S_TETX && o_tx_byte ==
        smsc_pkg::hex_char(i_status[smsc_pkg::STAT_BITS-8 +: 4]))
    else $error("status record not 40 characters");

  blk_limit_a: assert property (
    state_q == smsc_pkg::S_TCNT |-> blk_q <= smsc_pkg::BLK_MAX)
    else $error("block count above sixteen");

  unreg_nak_a: assert property (
    state_q == smsc_pkg::S_LOOK && !ent_ok
    |=> nak_q && err_q == smsc_pkg::ERR_DEVICE)
    else $error("unregistered index not refused");

  echo_cmd_a: assert property (
    state_q == smsc_pkg::S_TECHO && fire && pos_q == 6'h02
    |=> o_tx_byte == cmd_q && o_tx_valid)
    else $error("command letter not echoed");

  nak_hdr_a: assert property (
    state_q == smsc_pkg::S_THDR && fire && nak_q
    |=> o_tx_byte == smsc_pkg::NAK_C ##1 state_q == smsc_pkg::S_TECHO)
    else $error("negative reply header wrong");

endmodule : smsc_responder

// [testbench/smsc_host.sv]
`timescale 1ns/100ps
// ****************************************************************
// host side: reply sink that can stall
// ****************************************************************
module smsc_host (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_tx_ready,
  output logic            o_got,
  output logic      [7:0] o_ch
);
  logic [1:0] cnt_q;
  // slow host takes one char in four, to exercise hold
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'h1;
  assign o_tx_ready = !i_slow || (cnt_q == 2'h3);
  assign o_got      = i_tx_valid && o_tx_ready;
  assign o_ch       = i_tx_byte;
endmodule : smsc_host

// [testbench/serial_monitor_status_commands_tb.sv]
`timescale 1ns/100ps
module serial_monitor_status_commands_tb;
  logic clk = 1'b0, nrst = 1'b0, rxv = 1'b0, txv, txr, slow = 1'b0;
  logic got, rwr = 1'b0, rsg = 1'b0, drd;
  logic [7:0] rxb = 8'h00, txb, ch, ddat = 8'h00;
  logic [3:0] ridx = 4'h0;
  logic [5:0] rcnt = 6'h00;
  logic [15:0] rbase = 16'h0000, daddr;
  logic [159:0] st;
  logic [7:0] rxq[$];
  int n_fail = 0, n_checks = 0, cyc = 0;
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic string hx(logic [7:0] b);
    string s = "00";
    s[0] = (b[7:4] < 4'hA) ? 8'h30 + b[7:4] : 8'h37 + b[7:4];
    s[1] = (b[3:0] < 4'hA) ? 8'h30 + b[3:0] : 8'h37 + b[3:0];
    return s;
  endfunction : hx
  function automatic string bcc(string s);
    logic [7:0] a = 8'h00;
    foreach (s[i]) a += s[i];
    return hx(a);
  endfunction : bcc
  function automatic logic [7:0] dv(logic [15:0] a);
    return a[7:0] ^ 8'hC3;
  endfunction : dv
  task automatic fail(string m);
    n_fail++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic rg(logic [3:0] x, logic s, logic [5:0] c, logic [15:0] b);
    @(negedge clk);
    {rwr, ridx, rsg, rcnt, rbase} = {1'b1, x, s, c, b};
    @(negedge clk);
    rwr = 1'b0;
  endtask : rg
  // send a request, then compare the whole reply char by char
  task automatic xf(string rq, string rp, bit lc);
    int i;
    if (lc) rq = {rq, bcc(rq)};
    if (lc) rp = {rp, bcc(rp)};
    rxq.delete();
    foreach (rq[k])
    begin
      @(negedge clk);
      {rxv, rxb} = {1'b1, rq[k]};
    end
    @(negedge clk);
    rxv = 1'b0;
    for (i = 0; i < 3000 && rxq.size() < rp.len(); i++) @(posedge clk);
    repeat (20) @(posedge clk);
    n_checks++;
    if (rxq.size() != rp.len())
      fail("reply length");
    else
      foreach (rxq[k]) if (rxq[k] !== rp[k]) fail("reply char");
  endtask : xf
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_stat(bit lc);
    string s = "";
    for (int k = 0; k < 20; k++) s = {s, hx(st[8*k+:8])};
    xf($sformatf("%c01%cST%c", 8'h05, lc ? "r" : "R", 8'h04),
       $sformatf("%c01%cST%s%c", 8'h06, lc ? "r" : "R", s, 8'h03), lc);
  endtask : t_stat
  task automatic t_cont();
    rg(4'h3, 1'b1, 6'h01, 16'h0040);
    rg(4'h3, 1'b0, 6'h02, 16'h0010);
    slow = 1'b1;
    xf($sformatf("%c01Y03%c", 8'h05, 8'h04), $sformatf("%c01Y0302%s%s%c",
       8'h06, hx(dv(16'h0010)), hx(dv(16'h0011)), 8'h03), 1'b0);
    slow = 1'b0;
  endtask : t_cont
  task automatic t_single();
    rg(4'h1, 1'b1, 6'h02, 16'h0020);
    xf($sformatf("%c01y01%c", 8'h05, 8'h04),
       $sformatf("%c01y010202%s%s02%s%s%c", 8'h06,
       hx(dv(16'h0020)), hx(dv(16'h0021)), hx(dv(16'h0022)),
       hx(dv(16'h0023)), 8'h03), 1'b1);
  endtask : t_single
  // bad type, unknown letter, wrong check characters
  task automatic t_bad();
    xf($sformatf("%c01RSX%c", 8'h05, 8'h04),
       $sformatf("%c01RSX0031%c", 8'h15, 8'h03), 1'b0);
    xf($sformatf("%c01Q01%c", 8'h05, 8'h04),
       $sformatf("%c01Q010021%c", 8'h15, 8'h03), 1'b0);
    xf($sformatf("%c01rST%c00", 8'h05, 8'h04),
       {$sformatf("%c01rST0011%c", 8'h15, 8'h03),
        bcc($sformatf("%c01rST0011%c", 8'h15, 8'h03))}, 1'b0);
  endtask : t_bad
  task automatic t_nak();
    xf($sformatf("%c01y05%c", 8'h05, 8'h04),
       $sformatf("%c01y051132%c", 8'h15, 8'h03), 1'b1);
  endtask : t_nak
  task automatic t_foreign();
    xf($sformatf("%c02RST%c", 8'h05, 8'h04), "", 1'b0);
  endtask : t_foreign
  // ****************************************************************
  // clock, models and main sequence
  // ****************************************************************
  always #25 clk = ~clk;
  // device memory answers the cycle after a read, then scrambles
  always @(posedge clk) ddat <= drd ? dv(daddr) : ~ddat;
  always @(posedge clk) if (got === 1'b1) rxq.push_back(ch);
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail("timeout");
      end_of_test();
    end
  end
  smsc_host host_u (.i_clk_sys(clk), .i_nrst(nrst), .i_slow(slow),
    .i_tx_valid(txv), .i_tx_byte(txb), .o_tx_ready(txr), .o_got(got),
    .o_ch(ch));
  smsc_responder dut_u (.i_clk_sys(clk), .i_nrst(nrst),
    .i_station(8'h01), .i_rx_valid(rxv), .i_rx_byte(rxb),
    .o_tx_valid(txv), .o_tx_byte(txb), .i_tx_ready(txr), .i_reg_wr(rwr),
    .i_reg_idx(ridx), .i_reg_single(rsg), .i_reg_count(rcnt),
    .i_reg_base(rbase), .o_dev_rd(drd), .o_dev_addr(daddr),
    .i_dev_data(ddat), .i_status(st));
  initial
  begin
    for (int k = 0; k < 20; k++) st[8*k+:8] = 8'(k * 29 + 11);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_stat(1'b0);
    t_stat(1'b1);
    t_cont();
    t_single();
    t_nak();
    t_foreign();
    t_bad();
    end_of_test();
  end
endmodule : serial_monitor_status_commands_tb
